// ==== src/ust_pkg.sv ====
// Constants, types and helper functions for the serial transmitter.
// ==================================================================
// Notes on behaviour
// R1 - Transmit enable hands output pin to transmitter
// R2 - Synchronous mode times bits from serial clock
// R3 - Data port write loads buffer, starts sending
// R4 - Buffer moves to shifter when idle or after stop
// R5 - Shifter sends one frame at configured rate
// R6 - Upper bits beyond character width are dropped
// R7 - Ninth bit written first, sent as bit eight
// R8 - Empty flag shows whether buffer holds data
// R9 - Data port write clears empty flag at once
// R10 - Empty interrupt requested while flag and enables set
// R11 - Done flag sets after frame, buffer empty
// R12 - Done flag clears on service or one written
// R13 - Done interrupt raised when flag sets, enabled
// R14 - Parity bit inserted before first stop bit
// R15 - Disable waits until shifter and buffer empty
// R16 - Disabled transmitter releases the output pin
// R17 - Software programs rate and format before enabling
// R18 - Software changes settings only while idle
// R19 - Software clears done flag before each write
// R20 - Empty handler writes data or masks interrupt
// R21 - Software writes zero to empty flag position
// R22 - Parity is data exclusive-or, inverted for odd
// R23 - Low start, data LSB first, high stops
// R24 - Baud counter reloads at zero or divisor write
// R25 - Bit time is 16, 8 or 2 ticks
package ust_pkg;

  // ================================================================
  // Register map.
  localparam logic [11:0] OFF_DATA    = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_CTRL    = 12'h008;
  localparam logic [11:0] OFF_FORMAT  = 12'h00C;
  localparam logic [11:0] OFF_BAUD    = 12'h010;

  // ================================================================
  // Field positions.
  localparam int STAT_DONE      = 6;
  localparam int STAT_EMPTY     = 5;
  localparam int STAT_DOUBLE    = 1;
  localparam int CTRL_DONE_IE   = 6;
  localparam int CTRL_EMPTY_IE  = 5;
  localparam int CTRL_TRANSMIT_ENABLE      = 3;
  localparam int CTRL_XCK_SLAVE = 2;
  localparam int CTRL_NINTH     = 0;
  localparam int FMT_POLARITY   = 7;
  localparam int FMT_SYNC       = 6;
  localparam int FMT_PAR_ON     = 5;
  localparam int FMT_PAR_ODD    = 4;
  localparam int FMT_STOP2      = 3;
  localparam int FMT_SIZE_HI    = 2;
  localparam int FMT_SIZE_LO    = 0;
  localparam int BAUD_HI        = 11;

  // ================================================================
  // Reset values and encodings.
  localparam logic [7:0]  FORMAT_RST  = 8'h06;
  localparam logic [11:0] BAUD_RST    = 12'h000;
  localparam logic [2:0]  SIZE_NINE   = 3'h7;
  localparam logic [3:0]  PRE_NORMAL  = 4'hF;
  localparam logic [3:0]  PRE_DOUBLE  = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_DATA,
    ST_PARITY,
    ST_STOP1,
    ST_STOP2
  } ust_state_t;

  // Number of data bits for a size code.
  function automatic logic [3:0] ust_bits(input logic [2:0] size);
    case (size)
      3'h0:    ust_bits = 4'h5;
      3'h1:    ust_bits = 4'h6;
      3'h2:    ust_bits = 4'h7;
      3'h7:    ust_bits = 4'h9;
      default: ust_bits = 4'h8;
    endcase
  endfunction

  // Character as stored: bits past the width are cleared.
  function automatic logic [8:0] ust_mask(input logic [7:0] d, input logic ninth,
                                          input logic [2:0] size);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < ust_bits(size)) begin
        m[i] = 1'b1;
      end
    end
    ust_mask = {ninth, d} & m;
  endfunction

endpackage

// ==== src/ust_tx.sv ====
// Serial transmitter with APB register access.
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module ust_tx
  import ust_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt requests to the processor core.
  input  wire logic        global_irq_en,
  input  wire logic        tx_done_irq_ack,
  output logic             buffer_empty_irq,
  output logic             tx_done_irq,
  // Serial pins.
  input  wire logic        ext_serial_clock_pin,
  output logic             ext_serial_clock_out,
  output logic             ext_serial_clock_oe_n,
  output logic             serial_out_pin,
  output logic             serial_out_override
);

  // ================================================================
  // State.
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [8:0]  buf_data;
    logic        buf_full;
    logic [8:0]  shift;
    logic [3:0]  bit_cnt;
    ust_state_t  state;
    logic        tx_done;
    logic        dbl;
    logic        empty_ie;
    logic        done_ie;
    logic        transmit_enable;
    logic        xck_slave;
    logic        ninth;
    logic [7:0]  fmt;
    logic [11:0] baud;
    logic [11:0] baud_cnt;
    logic [3:0]  pre;
    logic [2:0]  xsync;
    logic        xck_out;
    logic        xck_oe_n;
    logic        txd;
    logic        own;
    logic        irq_empty;
    logic        irq_done;
  } ust_regs_t;

  ust_regs_t q;
  ust_regs_t next_q;

  logic access;
  logic wr_commit;
  logic wr_data;
  logic wr_baud;
  logic mapped;
  logic sync_mode;
  logic slave_mode;
  logic btick;
  logic bit_tick;
  logic busy;
  logic frame_end;
  logic load;
  logic par_bit;
  logic [31:0] rd_mux;

  // ================================================================
  // Bus decode and read mux.
  always_comb begin
    access    = psel && penable;
    wr_commit = access && q.pready && pwrite && !q.pslverr;
    wr_data   = wr_commit && (paddr == OFF_DATA);
    wr_baud   = wr_commit && (paddr == OFF_BAUD);
    mapped    = (paddr == OFF_DATA) || (paddr == OFF_STATUS) || (paddr == OFF_CTRL) ||
                (paddr == OFF_FORMAT) || (paddr == OFF_BAUD);
    rd_mux    = 32'h0000_0000;
    case (paddr)
      OFF_STATUS: begin
        rd_mux[STAT_DONE]   = q.tx_done;
        // R8 empty flag read
        rd_mux[STAT_EMPTY]  = !q.buf_full;
        rd_mux[STAT_DOUBLE] = q.dbl;
      end
      OFF_CTRL: begin
        rd_mux[CTRL_DONE_IE]   = q.done_ie;
        rd_mux[CTRL_EMPTY_IE]  = q.empty_ie;
        rd_mux[CTRL_TRANSMIT_ENABLE]      = q.transmit_enable;
        rd_mux[CTRL_XCK_SLAVE] = q.xck_slave;
        rd_mux[CTRL_NINTH]     = q.ninth;
      end
      OFF_FORMAT: rd_mux[7:0] = q.fmt;
      OFF_BAUD:   rd_mux[BAUD_HI:0] = q.baud;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  // ================================================================
  // Bit timing.
  always_comb begin
    sync_mode  = q.fmt[FMT_SYNC];
    slave_mode = sync_mode && q.xck_slave;
    btick      = (q.baud_cnt == BAUD_RST);
    busy       = q.buf_full || (q.state != ST_IDLE);
    // R2 R5 R25 bit tick source
    if (slave_mode) begin
      bit_tick = q.fmt[FMT_POLARITY] ? (q.xsync[2] && !q.xsync[1])
                                     : (q.xsync[1] && !q.xsync[2]);
    end else if (sync_mode) begin
      bit_tick = btick && (q.xck_out == q.fmt[FMT_POLARITY]);
    end else begin
      bit_tick = btick && (q.pre == (q.dbl ? PRE_DOUBLE : PRE_NORMAL));
    end
    frame_end = bit_tick && (((q.state == ST_STOP1) && !q.fmt[FMT_STOP2]) ||
                             (q.state == ST_STOP2));
    // R4 load when idle or after last stop
    load      = q.own && q.buf_full && ((q.state == ST_IDLE) || frame_end);
    // R22 even or odd parity
    par_bit   = (^q.shift) ^ q.fmt[FMT_PAR_ODD];
  end

  // ================================================================
  // Next state.
  always_comb begin
    next_q = q;

    // APB access takes two cycles; the write lands with pready.
    if (access && !q.pready) begin
      next_q.pready  = 1'b1;
      next_q.pslverr = !mapped;
      next_q.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      next_q.pready  = 1'b0;
      next_q.pslverr = 1'b0;
    end

    // R24 baud counter reload
    if (btick || wr_baud) begin
      next_q.baud_cnt = wr_baud ? pwdata[BAUD_HI:0] : q.baud;
    end else begin
      next_q.baud_cnt = q.baud_cnt - 12'h001;
    end

    // The synchroniser's first stage feeds only the second.
    next_q.xsync = {q.xsync[1:0], ext_serial_clock_pin};

    // R25 divide by sixteen or eight
    if (btick) begin
      next_q.pre = (q.pre == (q.dbl ? PRE_DOUBLE : PRE_NORMAL)) ? 4'h0 : q.pre + 4'h1;
    end
    // R25 master clock toggles per tick
    if (sync_mode && !slave_mode && q.own) begin
      if (btick) begin
        next_q.xck_out = !q.xck_out;
      end
    end else begin
      next_q.xck_out = q.fmt[FMT_POLARITY];
    end
    next_q.xck_oe_n = !(q.own && sync_mode && !slave_mode);

    // R23 frame sequencing
    if (bit_tick) begin
      case (q.state)
        ST_START: begin
          next_q.txd     = q.shift[0];
          next_q.bit_cnt = 4'h1;
          next_q.state   = ST_DATA;
        end
        ST_DATA: begin
          if (q.bit_cnt == ust_bits(q.fmt[FMT_SIZE_HI:FMT_SIZE_LO])) begin
            // R14 parity after last data bit
            if (q.fmt[FMT_PAR_ON]) begin
              next_q.txd   = par_bit;
              next_q.state = ST_PARITY;
            end else begin
              next_q.txd   = 1'b1;
              next_q.state = ST_STOP1;
            end
          end else begin
            next_q.txd     = q.shift[q.bit_cnt];
            next_q.bit_cnt = q.bit_cnt + 4'h1;
          end
        end
        ST_PARITY: begin
          next_q.txd   = 1'b1;
          next_q.state = ST_STOP1;
        end
        ST_STOP1: begin
          next_q.txd   = 1'b1;
          next_q.state = q.fmt[FMT_STOP2] ? ST_STOP2 : ST_IDLE;
        end
        ST_STOP2: begin
          next_q.txd   = 1'b1;
          next_q.state = ST_IDLE;
        end
        default: begin
          next_q.state = ST_IDLE;
        end
      endcase
    end

    // R12 done flag clears by service or one
    if (tx_done_irq_ack) begin
      next_q.tx_done = 1'b0;
    end
    if (wr_commit && (paddr == OFF_STATUS) && pwdata[STAT_DONE]) begin
      next_q.tx_done = 1'b0;
    end

    // R11 done set wins over clear
    if (frame_end && !q.buf_full) begin
      next_q.tx_done = 1'b1;
    end

    if (load) begin
      next_q.shift    = q.buf_data;
      next_q.buf_full = 1'b0;
      next_q.state    = ST_START;
      next_q.txd      = 1'b0;
      next_q.pre      = 4'h0;
    end

    // R3 R9 data write fills buffer
    if (wr_data) begin
      // R6 R7 mask width, ninth bit
      next_q.buf_data = ust_mask(pwdata[7:0],
                                 q.ninth && (q.fmt[FMT_SIZE_HI:FMT_SIZE_LO] == SIZE_NINE),
                                 q.fmt[FMT_SIZE_HI:FMT_SIZE_LO]);
      next_q.buf_full = 1'b1;
    end
    // R21 empty position ignored on writes
    if (wr_commit && (paddr == OFF_STATUS)) begin
      next_q.dbl = pwdata[STAT_DOUBLE];
    end
    if (wr_commit && (paddr == OFF_CTRL)) begin
      next_q.done_ie   = pwdata[CTRL_DONE_IE];
      next_q.empty_ie  = pwdata[CTRL_EMPTY_IE];
      next_q.transmit_enable      = pwdata[CTRL_TRANSMIT_ENABLE];
      next_q.xck_slave = pwdata[CTRL_XCK_SLAVE];
      next_q.ninth     = pwdata[CTRL_NINTH];
    end
    if (wr_commit && (paddr == OFF_FORMAT)) begin
      next_q.fmt = pwdata[7:0];
    end
    if (wr_baud) begin
      next_q.baud = pwdata[BAUD_HI:0];
    end

    // R1 R15 R16 pin ownership
    next_q.own = q.transmit_enable || (q.own && busy);
    if (!q.own) begin
      next_q.txd = 1'b1;
    end

    // R10 level request while empty
    next_q.irq_empty = global_irq_en && q.empty_ie && !q.buf_full;
    // R13 request when done flag set
    next_q.irq_done  = global_irq_en && q.done_ie && q.tx_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.state    <= ST_IDLE;
      q.fmt      <= FORMAT_RST;
      q.baud     <= BAUD_RST;
      q.baud_cnt <= BAUD_RST;
      q.txd      <= 1'b1;
      q.xck_oe_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ================================================================
  // Outputs.
  always_comb begin
    prdata                = q.prdata;
    pready                = q.pready;
    pslverr               = q.pslverr;
    buffer_empty_irq      = q.irq_empty;
    tx_done_irq           = q.irq_done;
    ext_serial_clock_out  = q.xck_out;
    ext_serial_clock_oe_n = q.xck_oe_n;
    serial_out_pin        = q.txd;
    serial_out_override   = q.own;
  end

  // ================================================================
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_data_write;
    wr_data;
  endsequence

  sequence s_last_stop_no_data;
    frame_end && !q.buf_full && !wr_data;
  endsequence

  a_write_fills_buf: assert property (s_data_write |=> q.buf_full) // R9
    else $error("data write did not fill the buffer");
  a_load_at_once: assert property (q.own && q.buf_full && q.state == ST_IDLE // R4
                                   |=> q.state == ST_START && !serial_out_pin)
    else $error("idle transmitter did not start a frame");
  a_done_after_frame: assert property (s_last_stop_no_data // R11
                                       |=> q.tx_done && q.state == ST_IDLE)
    else $error("done flag not set after frame");
  a_stop_is_high: assert property (q.state == ST_STOP1 || q.state == ST_STOP2 // R23
                                   |-> serial_out_pin)
    else $error("stop bit is not high");
  a_parity_value: assert property (q.state == ST_PARITY |-> serial_out_pin == par_bit) // R22
    else $error("parity bit value wrong");
  a_parity_order: assert property (bit_tick && q.state == ST_DATA && next_q.state != ST_DATA // R14
                                   |=> q.state == (q.fmt[FMT_PAR_ON] ? ST_PARITY : ST_STOP1))
    else $error("parity placement wrong");
  a_disable_defer: assert property (q.own && !q.transmit_enable && busy |=> q.own) // R15
    else $error("pin released while data pending");
  a_pin_release: assert property (q.own && !q.transmit_enable && !busy ##1 !q.transmit_enable // R16
                                  |-> !q.own ##1 serial_out_pin)
    else $error("pin not released after disable");
  a_empty_irq_level: assert property (global_irq_en && q.empty_ie && !q.buf_full // R10
                                      |=> buffer_empty_irq)
    else $error("empty interrupt not requested");
  a_done_irq_rise: assert property ($rose(q.tx_done) && q.done_ie && global_irq_en // R13
                                    |=> tx_done_irq)
    else $error("done interrupt not raised");
  a_baud_reload: assert property (btick && !wr_baud |=> q.baud_cnt == $past(q.baud)) // R24
    else $error("baud counter did not reload");
  a_ack_clears_done: assert property (tx_done_irq_ack && !frame_end |=> !q.tx_done) // R12
    else $error("done flag not cleared by service");

endmodule // ust_tx

// ==== tb/ust_rx_model.sv ====
// Remote serial receiver that decodes frames from the transmit line.
`timescale 1ns/1ps
module ust_rx_model (
  // Clock and line.
  input  wire logic       pclk,
  input  wire logic       line,
  input  wire logic       owned,
  // Frame format.
  input  wire logic [7:0] bit_cycles,
  input  wire logic [3:0] nbits,
  input  wire logic       par_on,
  input  wire logic       stop2,
  // Decoded frame.
  output logic [8:0]      rx_data,
  output logic            rx_par,
  output logic            rx_ok,
  output logic [7:0]      rx_count
);
  // ================================================================
  // Frame decoder.
  // Bits are sampled mid-bit so a short first bit still decodes.
  initial begin
    rx_data = 9'h000;
    rx_par = 1'h0;
    rx_ok = 1'h0;
    rx_count = 8'h00;
    forever begin
      // low start, data LSB first, high stops.
      @(negedge line iff owned);
      repeat (bit_cycles / 2) @(posedge pclk);
      rx_ok = (line === 1'h0);
      rx_data = 9'h000;
      for (int i = 0; i < nbits; i++) begin
        repeat (bit_cycles) @(posedge pclk);
        rx_data[i] = line;
      end
      if (par_on) begin
        repeat (bit_cycles) @(posedge pclk);
        rx_par = line;
      end
      repeat (bit_cycles) @(posedge pclk);
      rx_ok = rx_ok & (line === 1'h1);
      if (stop2) begin
        repeat (bit_cycles) @(posedge pclk);
        rx_ok = rx_ok & (line === 1'h1);
      end
      rx_count = rx_count + 8'h01;
    end
  end
endmodule // ust_rx_model

// ==== tb/ust_tx_test.sv ====
// Self-checking bench for the serial transmitter and its registers.
`timescale 1ns/1ps
module ust_tx_test;
  import ust_pkg::*;
  // ================================================================
  // Signals.
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        global_irq_en, tx_done_irq_ack, buffer_empty_irq, tx_done_irq;
  logic        ext_serial_clock_pin, ext_serial_clock_out, ext_serial_clock_oe_n;
  logic        serial_out_pin, serial_out_override, par_on, stop2, rx_par, rx_ok;
  logic [7:0]  bit_cycles, rx_count, seen;
  logic [3:0]  nbits;
  logic [8:0]  rx_data, e;
  int          num_errors, cmp_count;
  localparam logic [7:0] FMT [5] = '{8'h22, 8'h38, 8'h27, 8'h31, 8'h06};
  localparam logic [8:0] DAT [5] = '{9'h1FF, 9'h0E7, 9'h15A, 9'h02D, 9'h0C3};
  localparam logic       DBL [5] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1};

  ust_tx u_ust_tx (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .global_irq_en, .tx_done_irq_ack, .buffer_empty_irq, .tx_done_irq,
    .ext_serial_clock_pin, .ext_serial_clock_out, .ext_serial_clock_oe_n, .serial_out_pin,
    .serial_out_override);
  ust_rx_model u_ust_rx_model (.pclk, .line(serial_out_pin), .owned(serial_out_override),
    .bit_cycles, .nbits, .par_on, .stop2, .rx_data, .rx_par, .rx_ok, .rx_count);

  // ================================================================
  // Helpers.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask

  // One APB transfer; read data is taken in the cycle that pready stands.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    chk({31'h0, pready}, 32'h1, "pready");
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
    apb(1'h0, a, 32'h0);
    chk(q, x, m);
  endtask

  task automatic expect_frame(input logic [8:0] d, input logic p);
    int n;
    n = 0;
    while (rx_count === seen && n < 4000) begin
      @(negedge pclk);
      n++;
    end
    seen = rx_count;
    chk({31'h0, n < 4000}, 32'h1, "frame arrived");
    chk(rx_data, d, "frame data");
    chk(rx_ok, 1'h1, "start or stop level");
    if (par_on) chk(rx_par, p, "parity bit");
  endtask

  function automatic logic [3:0] nb(input logic [2:0] s);
    nb = (s < 3'h4) ? 4'h5 + 4'(s) : ((s == 3'h7) ? 4'h9 : 4'h8);
  endfunction

  // ================================================================
  // Clock and watchdog.
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end

  // ================================================================
  // Tests.
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    global_irq_en = 1'h0;
    tx_done_irq_ack = 1'h0;
    ext_serial_clock_pin = 1'h0;
    bit_cycles = 8'h20;
    nbits = 4'h8;
    par_on = 1'h0;
    stop2 = 1'h0;
    seen = 8'h00;
    num_errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    cyc(2);
    chk(serial_out_override, 1'h0, "pin released");
    chk(serial_out_pin, 1'h1, "idle line");
    rd(OFF_STATUS, 32'h20, "status reset");
    rd(OFF_FORMAT, 32'h06, "format reset");
    apb(1'h0, 12'h014, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    wr(OFF_BAUD, 32'h1);
    wr(OFF_FORMAT, 32'h06);
    wr(OFF_CTRL, 32'h08);
    cyc(2);
    chk(serial_out_override, 1'h1, "pin owned");
    wr(OFF_DATA, 32'h81);
    wr(OFF_DATA, 32'h42);
    rd(OFF_STATUS, 32'h00, "buffer held");
    wr(OFF_CTRL, 32'h00);
    cyc(2);
    chk(serial_out_override, 1'h1, "disable deferred");
    expect_frame(9'h081, 1'h0);
    expect_frame(9'h042, 1'h0);
    cyc(64);
    chk(serial_out_override, 1'h0, "pin returned");
    rd(OFF_STATUS, 32'h60, "done and empty");
    chk(tx_done_irq, 1'h0, "done irq masked");
    for (int i = 0; i < 5; i++) begin
      nbits = nb(FMT[i][2:0]);
      par_on = FMT[i][FMT_PAR_ON];
      stop2 = FMT[i][FMT_STOP2];
      bit_cycles = DBL[i] ? 8'h10 : 8'h20;
      e = DAT[i] & ((9'h001 << nbits) - 9'h001);
      wr(OFF_STATUS, {25'h0, 2'h2, 3'h0, DBL[i], 1'h0});
      rd(OFF_STATUS, {25'h0, 2'h1, 3'h0, DBL[i], 1'h0}, "done cleared");
      wr(OFF_FORMAT, {24'h0, FMT[i]});
      wr(OFF_CTRL, {24'h0, 8'h48} | {31'h0, DAT[i][8]});
      wr(OFF_DATA, {24'h0, DAT[i][7:0]});
      expect_frame(e, ^e ^ FMT[i][FMT_PAR_ODD]);
      cyc(bit_cycles * 2);
      rd(OFF_STATUS, {25'h0, 2'h3, 3'h0, DBL[i], 1'h0}, "done set");
    end
    @(posedge pclk);
    global_irq_en <= 1'h1;
    cyc(2);
    chk(tx_done_irq, 1'h1, "done irq");
    chk(buffer_empty_irq, 1'h0, "empty irq disabled");
    @(posedge pclk);
    tx_done_irq_ack <= 1'h1;
    @(posedge pclk);
    tx_done_irq_ack <= 1'h0;
    cyc(2);
    chk(tx_done_irq, 1'h0, "done irq served");
    rd(OFF_STATUS, 32'h22, "done cleared by service");
    wr(OFF_CTRL, 32'h28);
    cyc(2);
    chk(buffer_empty_irq, 1'h1, "empty irq");
    @(posedge pclk);
    global_irq_en <= 1'h0;
    cyc(2);
    chk(buffer_empty_irq, 1'h0, "empty irq gated");
    wr(OFF_FORMAT, 32'h46);
    cyc(2);
    chk(ext_serial_clock_oe_n, 1'h0, "clock pin driven");
    wr(OFF_CTRL, 32'h0C);
    bit_cycles = 8'h10;
    nbits = 4'h8;
    par_on = 1'h0;
    stop2 = 1'h0;
    wr(OFF_DATA, 32'hA5);
    fork
      repeat (24) begin
        repeat (8) @(posedge pclk);
        ext_serial_clock_pin <= !ext_serial_clock_pin;
      end
      expect_frame(9'h0A5, 1'h0);
    join
    chk(ext_serial_clock_oe_n, 1'h1, "clock pin is input");
    rd(OFF_STATUS, 32'h62, "slave frame done");
    test_done();
  end
endmodule // ust_tx_test
